// ---- shared/pss_pkg.sv ----
/*
 * Package for the summary status register block: register offsets,
 * field positions, reset values and interrupt layout.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
`default_nettype none
package pss_pkg;
    // ------------------------------------------------------------------
    // Register indices; the APB byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [4:0] PHY_SUMMARY_STATUS_IDX = 5'h10;
    localparam logic [4:0] TENBT_STATUS_IDX = 5'h1a;
    localparam logic [4:0] FALSE_CARRIER_IDX = 5'h14;
    localparam logic [4:0] RX_ERROR_IDX = 5'h15;
    localparam logic [4:0] AN_EXPANSION_IDX = 5'h06;
    localparam logic [4:0] BASIC_STATUS_IDX = 5'h01;
    localparam logic [4:0] PHY_CONTROL_IDX = 5'h19;
    localparam logic [4:0] SD_CONFIG_IDX = 5'h16;
    localparam logic [4:0] IRQ_STATUS_IDX = 5'h1c;
    localparam logic [4:0] IRQ_ENABLE_IDX = 5'h1d;
    localparam logic [4:0] IRQ_CLEAR_IDX = 5'h1e;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------------
    // Field positions in the summary status word.
    // ------------------------------------------------------------------
    localparam int BIT_RSVD_HI = 15;
    localparam int BIT_CROSSOVER = 14;
    localparam int BIT_RX_ERR = 13;
    localparam int BIT_POLARITY = 12;
    localparam int BIT_FALSE_CARRIER = 11;
    localparam int BIT_SIGNAL = 10;
    localparam int BIT_LOCK = 9;
    localparam int BIT_PAGE = 8;
    localparam int BIT_RSVD_LO = 7;
    localparam int BIT_REMOTE_FAULT = 6;
    // Other fields.
    localparam int BIT_TENBT_POLARITY = 4;
    localparam int BIT_SD_QUALIFY = 8;
    localparam int BIT_AN_PAGE = 1;
    localparam int BIT_BASIC_MODE_STATUS_REG_RFAULT = 4;
    localparam int BIT_XO_ENABLE = 15;
    localparam int BIT_XO_FORCE = 14;
    // ------------------------------------------------------------------
    // Reset values and interrupt layout.
    // ------------------------------------------------------------------
    localparam logic [15:0] SUMMARY_RESET = 16'h0000;
    localparam logic [15:0] PHY_CONTROL_RESET = 16'h8000;
    localparam logic [15:0] SD_CONFIG_RESET = 16'h0000;
    localparam int IRQ_W = 4;
    localparam int IRQ_RX_ERR = 0;
    localparam int IRQ_FALSE_CARRIER = 1;
    localparam int IRQ_PAGE = 2;
    localparam int IRQ_REMOTE_FAULT = 3;
endpackage : pss_pkg
`default_nettype wire

// ---- verilog/pss_latch_bit.sv ----
/*
 * One status latch: latch-high (sticky one) or latch-low (sticky zero).
 * Assumes the clear pulse and the source share the block clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pss_latch_bit #(
    parameter bit LATCH_LOW = 1'b0
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Source and clear.
    input wire logic src,
    input wire logic clear,
    // Latched value.
    output logic value
);
    // ------------------------------------------------------------------
    // Latch process: a new event beats a clear in the same cycle.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            value <= 1'b0;
        end else if (LATCH_LOW) begin
            if (!src) begin
                value <= 1'b0; // [RQ11]
            end else if (clear || value) begin
                value <= 1'b1; // [RQ11]
            end
        end else begin
            if (src) begin
                value <= 1'b1;
            end else if (clear) begin
                value <= 1'b0;
            end
        end
    end
endmodule : pss_latch_bit
`default_nettype wire

// ---- verilog/pss_irq.sv ----
/*
 * Sticky interrupt status with enable and write-one-to-clear.
 * Assumes event pulses on the block clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pss_irq #(
    parameter int W = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Events and software controls.
    input wire logic [W-1:0] events,
    input wire logic [W-1:0] clearMask,
    input wire logic clearWrite,
    input wire logic [W-1:0] enable,
    // Status and interrupt.
    output logic [W-1:0] status,
    output logic irq
);
    // Refuse a width that leaves no status bit at all.
    if (W < 1) begin : g_bad_width
        $error("W must be at least one");
    end
    // Sticky status: set wins over clear.
    always_ff @(posedge mclk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= events | (status & ~(clearWrite ? clearMask : '0));
        end
    end
    // Registered interrupt level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & enable);
        end
    end
endmodule : pss_irq
`default_nettype wire

// ---- verilog/pss_status_bank.sv ----
/*
 * Upper bits of the summary status register with the small neighbour
 * registers whose reads clear its latches, as an APB slave.
 * Assumes status sources are synchronous to mclk, except the raw
 * signal detect and descrambler lock, which come from analog logic.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1: Bits 15 and 7 ignore writes and always read zero.
// RQ2: Bit 14 shows crossover: one swapped pairs, zero normal pairs.
// RQ3: Crossover bit follows enable/force; tracks the automatic search otherwise.
// RQ4: Bit 13 latches receive errors until the error counter is read.
// RQ5: Bit 12 mirrors polarity bit, cleared by its own register read.
// RQ6: Bit 11 latches false carrier until the false carrier counter read.
// RQ7: Bit 10 is signal detect, qualified by lock when configured; latch low.
// RQ8: Bit 9 is descrambler lock, latch low, reset value zero.
// RQ9: Bit 8 copies page received, cleared only by expansion register read. Here reset also clears it.
// RQ10: Bit 6 sets on remote fault, cleared by basic status read or reset.
// RQ11: Latch-low bits hold zero until read, then follow the source.
module pss_status_bank
    import pss_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status sources.
    input wire logic autoCrossoverSwapped,
    input wire logic rxErrorEvent,
    input wire logic falseCarrierEvent,
    input wire logic polarityInverted,
    input wire logic rawSignalPresentPin,
    input wire logic descramblerLockPin,
    input wire logic pageReceivedEvent,
    input wire logic remoteFaultEvent,
    // Lower status bits joined into the same word.
    input wire logic [5:0] lowerStatus,
    // Interrupt.
    output logic irq
);
    import pss_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [4:0] idx);
        hit = (a[7:2] == {1'b0, idx}) && (a[1:0] == 2'b00);
    endfunction : hit

    logic access;
    logic rdAccess;
    logic wrAccess;
    assign access = psel && penable && pready;
    assign rdAccess = access && !pwrite;
    assign wrAccess = access && pwrite;

    // Read strobes that clear latches.
    logic rdSummary;
    logic rdRxErr;
    logic rdFalseCarrier;
    logic rdTenbt;
    logic rdExpansion;
    logic rdBasic;
    assign rdSummary = rdAccess && hit(paddr, PHY_SUMMARY_STATUS_IDX);
    assign rdRxErr = rdAccess && hit(paddr, RX_ERROR_IDX);
    assign rdFalseCarrier = rdAccess && hit(paddr, FALSE_CARRIER_IDX);
    assign rdTenbt = rdAccess && hit(paddr, TENBT_STATUS_IDX);
    assign rdExpansion = rdAccess && hit(paddr, AN_EXPANSION_IDX);
    assign rdBasic = rdAccess && hit(paddr, BASIC_STATUS_IDX);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    logic [1:0] sdSync;
    logic [1:0] lockSync;
    // Two flops for each analog status level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sdSync <= 2'b00;
            lockSync <= 2'b00;
        end else begin
            sdSync <= {sdSync[0], rawSignalPresentPin};
            lockSync <= {lockSync[0], descramblerLockPin};
        end
    end
    logic rawSignalPresent;
    logic descramblerLock;
    assign rawSignalPresent = sdSync[1];
    assign descramblerLock = lockSync[1];

    // ------------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------------
    logic [15:0] phyControlReg;
    logic [15:0] sdConfig;
    logic [IRQ_W-1:0] irqEnable;
    // Writable registers that steer the status logic.
    always_ff @(posedge mclk) begin
        if (rst) begin
            phyControlReg <= PHY_CONTROL_RESET;
            sdConfig <= SD_CONFIG_RESET;
            irqEnable <= '0;
        end else if (wrAccess) begin
            if (hit(paddr, PHY_CONTROL_IDX)) begin
                phyControlReg <= pwdata[15:0];
            end
            if (hit(paddr, SD_CONFIG_IDX)) begin
                sdConfig <= pwdata[15:0];
            end
            if (hit(paddr, IRQ_ENABLE_IDX)) begin
                irqEnable <= pwdata[IRQ_W-1:0];
            end
        end
    end
    logic crossoverAutoEnable;
    logic crossoverForce;
    assign crossoverAutoEnable = phyControlReg[BIT_XO_ENABLE];
    assign crossoverForce = phyControlReg[BIT_XO_FORCE];

    // ------------------------------------------------------------------
    // Status bits.
    // ------------------------------------------------------------------
    logic crossoverState;
    // Force wins; auto tracks the search; otherwise pairs stay normal.
    always_ff @(posedge mclk) begin
        if (rst) begin
            crossoverState <= 1'b0;
        end else if (crossoverForce) begin
            crossoverState <= 1'b1; // [RQ2] [RQ3]
        end else if (crossoverAutoEnable) begin
            crossoverState <= autoCrossoverSwapped; // [RQ3]
        end else begin
            crossoverState <= 1'b0; // [RQ2]
        end
    end

    logic rxErrLatch;
    logic falseCarrierLatch;
    logic polarityLatch;
    logic pageLatch;
    logic remoteFaultLatch;
    logic signalLatch;
    logic lockLatch;
    logic qualifiedSignal;
    // Qualified detect uses lock only when the config bit is set.
    assign qualifiedSignal = sdConfig[BIT_SD_QUALIFY] ?
        (rawSignalPresent && descramblerLock) : rawSignalPresent;

    // Receive error latch, cleared by the error counter read.
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_rxErr ( // [RQ4]
        .mclk(mclk), .rst(rst), .src(rxErrorEvent),
        .clear(rdRxErr), .value(rxErrLatch));
    // False carrier latch, cleared by the false carrier counter read.
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_fc ( // [RQ6]
        .mclk(mclk), .rst(rst), .src(falseCarrierEvent),
        .clear(rdFalseCarrier), .value(falseCarrierLatch));
    // Polarity copy, cleared by the 10BASE-T status read.
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_pol ( // [RQ5]
        .mclk(mclk), .rst(rst), .src(polarityInverted),
        .clear(rdTenbt), .value(polarityLatch));
    // Page received copy, cleared by the expansion register read.
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_page ( // [RQ9]
        .mclk(mclk), .rst(rst), .src(pageReceivedEvent),
        .clear(rdExpansion), .value(pageLatch));
    // Remote fault, cleared by the basic status read or reset.
    pss_latch_bit #(.LATCH_LOW(1'b0)) u_rf ( // [RQ10]
        .mclk(mclk), .rst(rst), .src(remoteFaultEvent),
        .clear(rdBasic), .value(remoteFaultLatch));
    // Signal detect, latch low, re-armed by a summary read.
    pss_latch_bit #(.LATCH_LOW(1'b1)) u_sd ( // [RQ7]
        .mclk(mclk), .rst(rst), .src(qualifiedSignal),
        .clear(rdSummary), .value(signalLatch));
    // Descrambler lock, latch low, re-armed by a summary read.
    pss_latch_bit #(.LATCH_LOW(1'b1)) u_lock ( // [RQ8]
        .mclk(mclk), .rst(rst), .src(descramblerLock),
        .clear(rdSummary), .value(lockLatch));

    // Assembled summary word.
    logic [15:0] summaryWord;
    always_comb begin
        summaryWord = SUMMARY_RESET;
        summaryWord[BIT_RSVD_HI] = 1'b0; // [RQ1]
        summaryWord[BIT_CROSSOVER] = crossoverState; // [RQ2]
        summaryWord[BIT_RX_ERR] = rxErrLatch;
        summaryWord[BIT_POLARITY] = polarityLatch;
        summaryWord[BIT_FALSE_CARRIER] = falseCarrierLatch;
        summaryWord[BIT_SIGNAL] = signalLatch;
        summaryWord[BIT_LOCK] = lockLatch;
        summaryWord[BIT_PAGE] = pageLatch;
        summaryWord[BIT_RSVD_LO] = 1'b0; // [RQ1]
        summaryWord[BIT_REMOTE_FAULT] = remoteFaultLatch;
        summaryWord[5:0] = lowerStatus;
    end

    // ------------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqStatus;
    logic irqLevel;
    always_comb begin
        irqEvents = '0;
        irqEvents[IRQ_RX_ERR] = rxErrorEvent;
        irqEvents[IRQ_FALSE_CARRIER] = falseCarrierEvent;
        irqEvents[IRQ_PAGE] = pageReceivedEvent;
        irqEvents[IRQ_REMOTE_FAULT] = remoteFaultEvent;
    end
    pss_irq #(.W(IRQ_W)) u_irq (
        .mclk(mclk),
        .rst(rst),
        .events(irqEvents),
        .clearMask(pwdata[IRQ_W-1:0]),
        .clearWrite(wrAccess && hit(paddr, IRQ_CLEAR_IDX)),
        .enable(irqEnable),
        .status(irqStatus),
        .irq(irqLevel)
    );
    assign irq = irqLevel;

    // ------------------------------------------------------------------
    // APB response.
    // ------------------------------------------------------------------
    logic [31:0] next_prdata;
    logic next_err;
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err = 1'b0;
        if (hit(paddr, PHY_SUMMARY_STATUS_IDX)) begin
            next_prdata[15:0] = summaryWord;
        end else if (hit(paddr, TENBT_STATUS_IDX)) begin
            next_prdata[BIT_TENBT_POLARITY] = polarityLatch;
        end else if (hit(paddr, AN_EXPANSION_IDX)) begin
            next_prdata[BIT_AN_PAGE] = pageLatch;
        end else if (hit(paddr, BASIC_STATUS_IDX)) begin
            next_prdata[BIT_BASIC_MODE_STATUS_REG_RFAULT] = remoteFaultLatch;
        end else if (hit(paddr, PHY_CONTROL_IDX)) begin
            next_prdata[15:0] = phyControlReg;
        end else if (hit(paddr, SD_CONFIG_IDX)) begin
            next_prdata[15:0] = sdConfig;
        end else if (hit(paddr, IRQ_STATUS_IDX)) begin
            next_prdata[IRQ_W-1:0] = irqStatus;
        end else if (hit(paddr, IRQ_ENABLE_IDX)) begin
            next_prdata[IRQ_W-1:0] = irqEnable;
        end else if (hit(paddr, RX_ERROR_IDX) ||
                     hit(paddr, FALSE_CARRIER_IDX) ||
                     hit(paddr, IRQ_CLEAR_IDX)) begin
            next_prdata = 32'h0000_0000;
        end else begin
            next_err = 1'b1;
        end
    end
    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_err;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    property p_rsvd;
        @(posedge mclk) disable iff (rst)
            rdSummary |-> (prdata[BIT_RSVD_HI] == 1'b0 &&
                           prdata[BIT_RSVD_LO] == 1'b0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // [RQ1]

    property p_force;
        @(posedge mclk) disable iff (rst)
            crossoverForce |=> crossoverState;
    endproperty
    a_force: assert property (p_force) else $error("force ignored"); // [RQ2]

    property p_auto;
        @(posedge mclk) disable iff (rst)
            (!crossoverForce && crossoverAutoEnable) |=>
                crossoverState == $past(autoCrossoverSwapped);
    endproperty
    a_auto: assert property (p_auto) else $error("auto not tracked"); // [RQ3]

    property p_rxerr;
        @(posedge mclk) disable iff (rst)
            (rxErrorEvent || (rxErrLatch && !rdRxErr)) |=> rxErrLatch;
    endproperty
    a_rxerr: assert property (p_rxerr) else $error("rx err lost"); // [RQ4]

    property p_rxclr;
        @(posedge mclk) disable iff (rst)
            (rdRxErr && !rxErrorEvent) |=> !rxErrLatch;
    endproperty
    a_rxclr: assert property (p_rxclr) else $error("rx err kept"); // [RQ4]

    property p_pol;
        @(posedge mclk) disable iff (rst)
            (polarityLatch && !rdTenbt && rdSummary) |=> polarityLatch;
    endproperty
    a_pol: assert property (p_pol) else $error("polarity cleared"); // [RQ5]

    property p_fc;
        @(posedge mclk) disable iff (rst)
            (falseCarrierLatch && !rdFalseCarrier) |=> falseCarrierLatch;
    endproperty
    a_fc: assert property (p_fc) else $error("false carrier lost"); // [RQ6]

    property p_sd;
        @(posedge mclk) disable iff (rst)
            !qualifiedSignal |=> !signalLatch;
    endproperty
    a_sd: assert property (p_sd) else $error("signal not low"); // [RQ7]

    property p_lock;
        @(posedge mclk) disable iff (rst)
            (!lockLatch && !rdSummary) |=> !lockLatch;
    endproperty
    a_lock: assert property (p_lock) else $error("lock rose unread"); // [RQ8]

    property p_page;
        @(posedge mclk) disable iff (rst)
            (pageLatch && !rdExpansion) |=> pageLatch;
    endproperty
    a_page: assert property (p_page) else $error("page lost"); // [RQ9]

    property p_rf;
        @(posedge mclk) disable iff (rst)
            (rdBasic && !remoteFaultEvent) |=> !remoteFaultLatch;
    endproperty
    a_rf: assert property (p_rf) else $error("fault not cleared"); // [RQ10]
endmodule : pss_status_bank
`default_nettype wire

// ---- verification/pss_apb_master.sv ----
/*
 * Management-side partner: an APB master that performs one transfer
 * per call of its task and reports data, error and a timeout.
 * Assumes a single clock and a slave that drives pready itself.
 */
`timescale 1ns/100ps
`default_nettype none
module pss_apb_master
    import pss_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Request side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [pss_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    // Answer side.
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idles with nothing selected.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
    end

    // One setup cycle, then access until pready is seen high.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rdat,
                        output logic err, output logic to);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        to = (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : pss_apb_master
`default_nettype wire

// ---- verification/phy_status_upper_bits_test.sv ----
/*
 * Self-checking bench for the summary status bank: reset values,
 * crossover modes, read-cleared latches, interrupts, latch-low bits.
 * Assumes the APB partner model and the package of the design.
 */
`timescale 1ns/100ps
`default_nettype none
module phy_status_upper_bits_test;
    import pss_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances.
    // ------------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic xoIn = 1'b0;
    logic sdIn = 1'b0;
    logic lockIn = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [5:0] lowIn = 6'h00;
    int errorCnt = 0;
    int totalChecks = 0;
    int seed = 32'hd19015f3;
    logic [4:0] clrIdx [5] = '{RX_ERROR_IDX, FALSE_CARRIER_IDX,
        AN_EXPANSION_IDX, BASIC_STATUS_IDX, TENBT_STATUS_IDX};
    int posTab [5] = '{BIT_RX_ERR, BIT_FALSE_CARRIER, BIT_PAGE,
        BIT_REMOTE_FAULT, BIT_POLARITY};

    // Clock of 10 ns.
    always #5 mclk = ~mclk;

    pss_status_bank u_dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .autoCrossoverSwapped(xoIn),
        .rxErrorEvent(ev[0]), .falseCarrierEvent(ev[1]),
        .pageReceivedEvent(ev[2]), .remoteFaultEvent(ev[3]),
        .polarityInverted(ev[4]), .rawSignalPresentPin(sdIn),
        .descramblerLockPin(lockIn), .lowerStatus(lowIn), .irq(irq));

    pss_apb_master u_mst (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------------
    // Report, compare and bus tasks.
    // ------------------------------------------------------------------
    task automatic endOfTest;
        $display("Checks %0d, mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endOfTest

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp,
                           input logic [31:0] mask);
        totalChecks++;
        if ((got & mask) !== (exp & mask)) begin
            errorCnt++;
            $display("Error at %0t: got %h expected %h", $time,
                     got & mask, exp & mask);
        end
    endtask : chkWord

    task automatic chkFlag(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkFlag

    // Byte address is four times the register index.
    function automatic logic [7:0] ba(input logic [4:0] idx);
        return {1'b0, idx, 2'b00};
    endfunction : ba

    // Crossover bit expected from force, auto enable and search state.
    function automatic logic xoExp(input logic en, input logic frc,
                                   input logic in);
        return frc | (en & in);
    endfunction : xoExp

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] d,
                        output logic e);
        logic to;
        u_mst.xfer(w, a, wd, d, e, to);
        if (to) begin
            errorCnt++;
            endOfTest();
        end
    endtask : xfer

    task automatic rd(input logic [4:0] idx, output logic [31:0] d);
        logic e;
        xfer(1'b0, ba(idx), 32'h0, d, e);
    endtask : rd

    task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        xfer(1'b1, ba(idx), wd, d, e);
    endtask : wr

    task automatic rdChk(input logic [4:0] idx, input logic [31:0] exp,
                         input logic [31:0] mask);
        logic [31:0] d;
        rd(idx, d);
        chkWord(d, exp, mask);
    endtask : rdChk

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] b;
        logic e;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rdChk(PHY_SUMMARY_STATUS_IDX, 32'h0, 32'hffffffc0);
        rdChk(PHY_CONTROL_IDX, {16'h0, PHY_CONTROL_RESET}, 32'hffffffff);
        wr(PHY_SUMMARY_STATUS_IDX, 32'hffffffff);
        rdChk(PHY_SUMMARY_STATUS_IDX, 32'h0, 32'hffffffc0);
        $display("Test reset and reserved done");
        // Every combination of enable, force and search state.
        for (int m = 0; m < 8; m++) begin
            wr(PHY_CONTROL_IDX, {16'h0, m[2], m[1], 14'h0});
            xoIn <= m[0];
            repeat (3) @(posedge mclk);
            b = {17'h0, xoExp(m[2], m[1], m[0]), 14'h0};
            rdChk(PHY_SUMMARY_STATUS_IDX, b, 32'h4000);
        end
        wr(PHY_CONTROL_IDX, {16'h0, PHY_CONTROL_RESET});
        // Random search states and lower bits under auto mode.
        for (int k = 0; k < 24; k++) begin
            lowIn <= 6'($random(seed));
            xoIn <= 1'($random(seed));
            repeat (3) @(posedge mclk);
            b = {17'h0, xoIn, 8'h0, lowIn};
            rdChk(PHY_SUMMARY_STATUS_IDX, b, 32'h403f);
        end
        $display("Test crossover done");
        // Events: sticky until their own register is read.
        wr(IRQ_ENABLE_IDX, 32'h5);
        for (int i = 0; i < 5; i++) begin
            ev <= 5'h01 << i;
            @(posedge mclk);
            ev <= 5'h00;
            repeat (2) @(posedge mclk);
            b = 32'h1 << posTab[i];
            rdChk(PHY_SUMMARY_STATUS_IDX, b, b);
            rdChk(PHY_SUMMARY_STATUS_IDX, b, b);
            if (i < 4) begin
                chkFlag(irq, (i == 0 || i == 2));
                rdChk(IRQ_STATUS_IDX, 32'h1 << i, 32'hf);
                wr(IRQ_CLEAR_IDX, 32'h1 << i);
                repeat (2) @(posedge mclk);
                chkFlag(irq, 1'b0);
            end
            rd(clrIdx[i], d);
            rdChk(PHY_SUMMARY_STATUS_IDX, 32'h0, b);
        end
        $display("Test latches and interrupt done");
        // Latch-low bits: hold a drop until read, then follow.
        sdIn <= 1'b1;
        lockIn <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(PHY_SUMMARY_STATUS_IDX, d);
        rdChk(PHY_SUMMARY_STATUS_IDX, 32'h600, 32'h600);
        for (int q = 0; q < 2; q++) begin
            wr(SD_CONFIG_IDX, q << BIT_SD_QUALIFY);
            lockIn <= 1'b0;
            repeat (4) @(posedge mclk);
            lockIn <= 1'b1;
            repeat (4) @(posedge mclk);
            b = (q == 0) ? 32'h400 : 32'h0;
            rdChk(PHY_SUMMARY_STATUS_IDX, b, 32'h600);
            rdChk(PHY_SUMMARY_STATUS_IDX, 32'h600, 32'h600);
        end
        $display("Test latch-low done");
        // Mid-run reset clears a remote fault latched just before it.
        ev <= 5'h08;
        @(posedge mclk);
        ev <= 5'h00;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdChk(PHY_SUMMARY_STATUS_IDX, 32'h0, 32'h40);
        rdChk(IRQ_STATUS_IDX, 32'h0, 32'hf);
        // Unmapped address answers with an error and zero data.
        xfer(1'b0, 8'hfc, 32'h0, d, e);
        chkFlag(e, 1'b1);
        chkWord(d, 32'h0, 32'hffffffff);
        $display("Test reset and unmapped done");
        endOfTest();
    end

    // Watchdog against a hung run.
    initial begin
        repeat (20000) @(posedge mclk);
        errorCnt++;
        endOfTest();
    end
endmodule : phy_status_upper_bits_test
`default_nettype wire
